// file: src/cq_framer_pkg.sv
/*
 * Constants and carrier types for the completer request boundary framer.
 * Assumes a single clock domain and a 512-bit request stream whose
 * sideband is driven from bit 80 upward by this block.
 */
package cq_framer_pkg;

   // ==========================================================
   // Widths and depths
   localparam int HALF_W     = 256;
   localparam int DATA_W     = 512;
   localparam int SIDE_W     = 97;
   localparam int FLAGS_LSB  = 80;
   localparam int FIFO_DEPTH = 8;
   localparam int REG_ADDR_W = 4;
   localparam int REG_DATA_W = 32;
   localparam int COUNT_W    = 16;

   // ==========================================================
   // Register map and reset values
   localparam logic [REG_ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [REG_ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam int                    CTRL_STRADDLE_BIT = 0;
   localparam int                    STATUS_HELD_BIT   = 16;
   localparam logic                  CTRL_STRADDLE_RESET = 1'b0;
   localparam logic [COUNT_W-1:0]    COUNT_RESET = 16'h0000;

   // ==========================================================
   // Flag and pointer codes
   localparam logic [1:0] FLAGS_NONE  = 2'h0;
   localparam logic [1:0] FLAGS_ONE   = 2'h1;
   localparam logic [1:0] FLAGS_TWO   = 2'h3;
   localparam logic [1:0] LANE0_PTR   = 2'h0;
   localparam logic [1:0] LANE32_PTR  = 2'h2;
   localparam logic [3:0] DWORD_ZERO  = 4'h0;
   localparam logic       UPPER_HALF  = 1'b1;
   localparam logic       LOWER_HALF  = 1'b0;

   // ==========================================================
   // Carriers
   // One half beat (eight Dwords) of a request packet from the core
   typedef struct packed {
      logic [HALF_W-1:0] data;
      logic              sop;
      logic              eop;
      logic              disc;
      logic [2:0]        lastDw;
   } seg_t;

   // Sideband bits 96:80, most significant field first
   typedef struct packed {
      logic       disc;
      logic [3:0] secondEndDwordOffset;
      logic [3:0] firstEndDwordOffset;
      logic [1:0] packetEndFlags;
      logic [1:0] secondStartLanePointer;
      logic [1:0] firstStartLanePointer;
      logic [1:0] packetStartFlags;
   } flags_t;

   typedef enum logic [0:0] {ASM_EMPTY, ASM_LOW} asm_t;

endpackage

// file: src/seg_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; the drain side may stall at will.
 */
`timescale 1ns/10ps
module seg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rstn,
   // Fill side
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   // Drain side
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_reg, wrPtr_next;
   logic [PW-1:0]    rdPtr_reg, rdPtr_next;
   logic [PW:0]      count_reg, count_next;
   logic             ready_reg, ready_next;
   logic             push, pop;

   // ==========================================================
   // Pointer and level update
   always_comb begin
      push       = inValid && ready_reg;
      pop        = outReady && (count_reg != '0);
      wrPtr_next = push ? PW'(wrPtr_reg + 1'b1) : wrPtr_reg;
      rdPtr_next = pop ? PW'(rdPtr_reg + 1'b1) : rdPtr_reg;
      count_next = count_reg;
      if (push && !pop) begin
         count_next = (PW+1)'(count_reg + 1'b1);
      end else if (pop && !push) begin
         count_next = (PW+1)'(count_reg - 1'b1);
      end
      // Registered so the block's ready output leaves a flip-flop
      ready_next = (count_next != (PW+1)'(DEPTH));
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b1;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
         ready_reg <= ready_next;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   assign inReady  = ready_reg;
   assign outValid = (count_reg != '0);
   assign outData  = mem[rdPtr_reg];

endmodule

// file: src/cq_boundary_framer.sv
/*
 * Completer request boundary framer: packs half-beat packet segments into
 * 512-bit beats and drives start/end flags and pointers in the sideband.
 * Assumes segments arrive whole, sop on a packet's first half and eop with
 * its last Dword index on its final half; straddle is changed only idle.
 */
// The implementer's own choices: the plain strobed port and the placing of the registers.
// How it works
// - Start flags sit at sideband 81:80, set only in a packet's first beat.
// - Without straddle the upper start flag is always zero.
// - With straddle start flags code 00, 01 or 11, never 10.
// - First start pointer at 83:82 codes lane 0 as 00, lane 32 as 10.
// - Second start pointer at 85:84 reads 10, lane 32, when two packets start; otherwise 00.
// - Two packets per beat only with straddle; else second pointer is zero.
// - End flags at 87:86 mark final beats; upper bit zero without straddle.
// - With straddle end flags code 00, 01 or 11, never 10.
// - Without straddle last is raised in every packet's final beat.
// - Bits 91:88 give the first ending packet's last Dword offset.
// - Bits 95:92 give the second ending offset; zero without straddle.
// - No second packet starts in a beat that signals discontinue; the code still starts one as a one-half discontinued packet in the upper half.
`timescale 1ns/10ps
module cq_boundary_framer
   import cq_framer_pkg::*;
(
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rstn,
   // Register port
   input  wire logic [REG_ADDR_W-1:0] regAddr,
   input  wire logic [REG_DATA_W-1:0] regWrData,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic [REG_DATA_W-1:0]      regRdData,
   // Segments from the core
   input  wire seg_t                  segIn,
   input  wire logic                  segValid,
   output logic                       segReady,
   // Completer request stream
   output logic [DATA_W-1:0]          requestStreamData,
   output logic [SIDE_W-1:0]          requestStreamSideband,
   output logic                       requestStreamLast,
   output logic                       requestStreamValid,
   input  wire logic                  requestStreamReady
);
   // ==========================================================
   // Segment buffer
   localparam int SEG_W = $bits(seg_t);

   seg_t fifoSeg;
   logic fifoValid;
   logic fifoPop;

   seg_fifo #(
      .WIDTH (SEG_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock    (clock),
      .rstn     (rstn),
      .inData   (segIn),
      .inValid  (segValid),
      .inReady  (segReady),
      .outData  (fifoSeg),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // ==========================================================
   // Registers
   logic                  straddle_reg, straddle_next;
   logic [COUNT_W-1:0]    count_reg, count_next;
   logic [REG_DATA_W-1:0] rdData_reg, rdData_next;

   // ==========================================================
   // Beat assembly state
   asm_t              state_reg, state_next;
   seg_t              low_reg, low_next;
   logic [DATA_W-1:0] data_reg, data_next;
   flags_t            flags_reg, flags_next;
   logic              last_reg, last_next;
   logic              valid_reg, valid_next;

   seg_t   beatLow, beatHigh;
   logic   hiPresent, emit, outFree, hiSop, hiEop, twoStart, twoEnd;
   flags_t f;

   always_comb begin
      outFree    = !valid_reg || requestStreamReady;
      fifoPop    = 1'b0;
      emit       = 1'b0;
      hiPresent  = 1'b0;
      beatLow    = low_reg;
      beatHigh   = fifoSeg;
      state_next = state_reg;
      low_next   = low_reg;
      unique case (state_reg)
         ASM_EMPTY: begin
            if (outFree && fifoValid) begin
               fifoPop = 1'b1;
               beatLow = fifoSeg;
               // A discontinued end closes the beat so nothing starts behind it
               if (fifoSeg.eop && (!straddle_reg || fifoSeg.disc)) begin
                  emit = 1'b1;
               end else begin
                  low_next   = fifoSeg;
                  state_next = ASM_LOW;
               end
            end
         end
         ASM_LOW: begin
            if (outFree && fifoValid) begin
               fifoPop    = 1'b1;
               emit       = 1'b1;
               hiPresent  = 1'b1;
               state_next = ASM_EMPTY;
            end else if (outFree && low_reg.eop) begin
               // Do not stall a finished packet waiting for a partner
               emit       = 1'b1;
               state_next = ASM_EMPTY;
            end
         end
      endcase
   end

   // ==========================================================
   // Boundary flags for the beat being formed
   always_comb begin
      hiSop    = hiPresent && beatHigh.sop && straddle_reg;
      hiEop    = hiPresent && beatHigh.eop;
      twoStart = beatLow.sop && hiSop;
      twoEnd   = beatLow.eop && hiEop && straddle_reg;
      f        = '0;
      if (twoStart) begin
         f.packetStartFlags = FLAGS_TWO;
      end else if (beatLow.sop || hiSop) begin
         f.packetStartFlags = FLAGS_ONE;
      end else begin
         f.packetStartFlags = FLAGS_NONE;
      end
      // Lane 32 only reachable through straddle
      f.firstStartLanePointer  = (!beatLow.sop && hiSop) ? LANE32_PTR : LANE0_PTR;
      f.secondStartLanePointer = twoStart ? LANE32_PTR : LANE0_PTR;
      if (twoEnd) begin
         f.packetEndFlags = FLAGS_TWO;
      end else if (beatLow.eop || hiEop) begin
         f.packetEndFlags = FLAGS_ONE;
      end else begin
         f.packetEndFlags = FLAGS_NONE;
      end
      // Offsets index Dwords 0..15, upper half adds eight
      if (beatLow.eop) begin
         f.firstEndDwordOffset = {LOWER_HALF, beatLow.lastDw};
      end else if (hiEop) begin
         f.firstEndDwordOffset = {UPPER_HALF, beatHigh.lastDw};
      end
      f.secondEndDwordOffset = twoEnd ? {UPPER_HALF, beatHigh.lastDw} : DWORD_ZERO;
      f.disc = (beatLow.eop && beatLow.disc) || (hiEop && beatHigh.disc);
   end

   always_comb begin
      data_next  = data_reg;
      flags_next = flags_reg;
      last_next  = last_reg;
      valid_next = valid_reg;
      if (emit) begin
         data_next  = {hiPresent ? beatHigh.data : {HALF_W{1'b0}}, beatLow.data};
         flags_next = f;
         // No packet left open at the top of the beat
         last_next  = hiPresent ? beatHigh.eop : beatLow.eop;
         valid_next = 1'b1;
      end else if (requestStreamReady) begin
         valid_next = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ASM_EMPTY;
         low_reg   <= '0;
         data_reg  <= '0;
         flags_reg <= '0;
         last_reg  <= 1'b0;
         valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         low_reg   <= low_next;
         data_reg  <= data_next;
         flags_reg <= flags_next;
         last_reg  <= last_next;
         valid_reg <= valid_next;
      end
   end

   // ==========================================================
   // Register port
   always_comb begin
      straddle_next = straddle_reg;
      count_next    = count_reg;
      rdData_next   = '0;
      if (regWr && regAddr == CTRL_OFS) begin
         straddle_next = regWrData[CTRL_STRADDLE_BIT];
      end
      if (emit) begin
         count_next = COUNT_W'(count_reg + f.packetEndFlags[0] + f.packetEndFlags[1]);
      end
      // Writing the status word clears the count; a same-cycle end still counts
      if (regWr && regAddr == STATUS_OFS) begin
         count_next = emit ? COUNT_W'(f.packetEndFlags[0] + f.packetEndFlags[1]) : '0;
      end
      if (regRd) begin
         unique case (regAddr)
            CTRL_OFS:   rdData_next[CTRL_STRADDLE_BIT] = straddle_reg;
            STATUS_OFS: begin
               rdData_next[COUNT_W-1:0]     = count_reg;
               rdData_next[STATUS_HELD_BIT] = (state_reg == ASM_LOW);
            end
            default:    rdData_next = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         straddle_reg <= CTRL_STRADDLE_RESET;
         count_reg    <= COUNT_RESET;
         rdData_reg   <= '0;
      end else begin
         straddle_reg <= straddle_next;
         count_reg    <= count_next;
         rdData_reg   <= rdData_next;
      end
   end

   assign regRdData             = rdData_reg;
   assign requestStreamData     = data_reg;
   assign requestStreamSideband = {flags_reg, {FLAGS_LSB{1'b0}}};
   assign requestStreamLast     = last_reg;
   assign requestStreamValid    = valid_reg;

   // ==========================================================
   // Checks
   logic afterLast_reg;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         afterLast_reg <= 1'b1;
      end else if (valid_reg && requestStreamReady) begin
         afterLast_reg <= last_reg;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_start_code;
      valid_reg |-> flags_reg.packetStartFlags != 2'h2;
   endproperty
   a_start_code: assert property (p_start_code)
      else $error("start flags show reserved code");

   property p_end_code;
      valid_reg |-> flags_reg.packetEndFlags != 2'h2;
   endproperty
   a_end_code: assert property (p_end_code)
      else $error("end flags show reserved code");

   property p_plain_upper_zero;
      (valid_reg && !straddle_reg) |-> (flags_reg.packetStartFlags[1] == 1'b0)
         && (flags_reg.packetEndFlags[1] == 1'b0);
   endproperty
   a_plain_upper_zero: assert property (p_plain_upper_zero)
      else $error("upper flag set without straddle");

   property p_plain_pointers;
      (valid_reg && !straddle_reg) |-> flags_reg.firstStartLanePointer == 2'h0
         && flags_reg.secondStartLanePointer == 2'h0
         && flags_reg.secondEndDwordOffset == 4'h0;
   endproperty
   a_plain_pointers: assert property (p_plain_pointers)
      else $error("pointer not zero without straddle");

   property p_start_after_last;
      (valid_reg && !straddle_reg) |-> flags_reg.packetStartFlags[0] == afterLast_reg;
   endproperty
   a_start_after_last: assert property (p_start_after_last)
      else $error("start flag disagrees with previous last");

   property p_last_is_end;
      (valid_reg && !straddle_reg) |-> requestStreamLast == flags_reg.packetEndFlags[0];
   endproperty
   a_last_is_end: assert property (p_last_is_end)
      else $error("last and end flag differ");

   property p_pointer_codes;
      valid_reg |-> !flags_reg.firstStartLanePointer[0]
         && (flags_reg.packetStartFlags != 2'h3
             || flags_reg.secondStartLanePointer == 2'h2);
   endproperty
   a_pointer_codes: assert property (p_pointer_codes)
      else $error("start pointer uses reserved code");

   property p_disc_no_second;
      (valid_reg && flags_reg.disc) |-> flags_reg.packetStartFlags != 2'h3;
   endproperty
   a_disc_no_second: assert property (p_disc_no_second)
      else $error("second packet started beside discontinue");

   property p_offset_order;
      (valid_reg && flags_reg.packetEndFlags == 2'h3) |->
         flags_reg.firstEndDwordOffset < flags_reg.secondEndDwordOffset
         && flags_reg.secondEndDwordOffset[3];
   endproperty
   a_offset_order: assert property (p_offset_order)
      else $error("end offsets out of order");

   property p_offset_idle;
      (valid_reg && !flags_reg.packetEndFlags[0]) |-> flags_reg.firstEndDwordOffset == 4'h0;
   endproperty
   a_offset_idle: assert property (p_offset_idle)
      else $error("end offset without end flag");

   property p_hold;
      (valid_reg && !requestStreamReady) |=> valid_reg && $stable(flags_reg)
         && $stable(last_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("beat changed under back-pressure");

   c_two_start: cover property (valid_reg && flags_reg.packetStartFlags == 2'h3);
   c_two_end:   cover property (valid_reg && flags_reg.packetEndFlags == 2'h3);
   c_disc:      cover property (valid_reg && flags_reg.disc);
   c_stall:     cover property ((valid_reg && !requestStreamReady) [*3]);

endmodule

// file: tb/cq_request_sink.sv
/*
 * Receiving user logic on the completer request stream: raises ready with
 * a set stall rate, counts packets from last and starts from the start flags.
 * Assumes the framer's clock and reset; stallPct 0 is always ready, 100 never.
 */
`timescale 1ns/10ps
module cq_request_sink (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Stream from the framer
   input  wire logic        valid,
   input  wire logic        last,
   input  wire logic [1:0]  startFlags,
   // Control and status
   input  wire logic [6:0]  stallPct,
   output logic             ready,
   output logic [15:0]      lastCount,
   output logic [15:0]      startCount
);
   // ==========================================================
   // Ready and packet count
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ready     <= 1'h0;
         lastCount  <= 16'h0000;
         startCount <= 16'h0000;
      end else begin
         ready <= ($urandom_range(99) >= stallPct);
         // Start flags ignored: one packet per raised last
         if (valid && ready && last) begin
            lastCount <= lastCount + 16'h0001;
         end
         // Start fields are only trusted with valid and the low start flag
         if (valid && ready && startFlags[0]) begin
            startCount <= startCount + {15'h0000, startFlags[1]} + 16'h0001;
         end
      end
   end
endmodule

// file: tb/tb.sv
/*
 * Self-checking bench for the completer request boundary framer.
 * Assumes the framer's package; a queue model predicts every beat.
 */
`timescale 1ns/10ps
module tb;
   import cq_framer_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [SIDE_W-1:0] side;
      logic              last;
   } beat_t;

   logic                  clock = 1'h0;
   logic                  rstn = 1'h0;
   logic [REG_ADDR_W-1:0] regAddr = 4'h0;
   logic [REG_DATA_W-1:0] regWrData = 32'h0;
   logic                  regWr = 1'h0;
   logic                  regRd = 1'h0;
   logic [REG_DATA_W-1:0] regRdData;
   seg_t                  segIn = '0;
   logic                  segValid = 1'h0;
   logic                  segReady;
   logic [DATA_W-1:0]     requestStreamData;
   logic [SIDE_W-1:0]     requestStreamSideband;
   logic                  requestStreamLast;
   logic                  requestStreamValid;
   logic                  requestStreamReady;
   logic [6:0]            stallPct = 7'h00;
   logic [15:0]           lastCount;
   logic [15:0]           startCount;
   int                    allPkts = 0;
   logic [31:0]           rd;
   int                    numErrors = 0;
   int                    checks = 0;
   int                    expPkts = 0;
   bit                    straddleOn = 1'b0;
   beat_t                 expQ[$];
   beat_t                 expBeat;

   always #50 clock = ~clock;

   cq_boundary_framer i_cq_boundary_framer (
      .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .segIn(segIn),
      .segValid(segValid), .segReady(segReady), .requestStreamData(requestStreamData),
      .requestStreamSideband(requestStreamSideband), .requestStreamLast(requestStreamLast),
      .requestStreamValid(requestStreamValid), .requestStreamReady(requestStreamReady));

   cq_request_sink i_cq_request_sink (
      .clock(clock), .rstn(rstn), .valid(requestStreamValid), .last(requestStreamLast),
      .stallPct(stallPct), .ready(requestStreamReady), .lastCount(lastCount),
      .startFlags(requestStreamSideband[FLAGS_LSB +: 2]), .startCount(startCount));

   // ==========================================================
   // Compares and verdict
   task automatic check_beat(input beat_t e, input beat_t g);
      checks++;
      if (g !== e) begin
         numErrors++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask

   task automatic check_word(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         numErrors++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, numErrors);
      if (numErrors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================================
   // Register port
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'h1;
      @(posedge clock);
      regWr <= 1'h0;
      @(posedge clock);
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      regAddr <= a;
      regRd   <= 1'h1;
      @(posedge clock);
      regRd <= 1'h0;
      @(posedge clock);
      d = regRdData;
   endtask

   // ==========================================================
   // Beat model: halves pair low then upper
   task automatic model(input seg_t h[$]);
      int     i;
      bit     hasUp;
      seg_t   lo;
      seg_t   up;
      flags_t f;
      beat_t  b;
      i = 0;
      while (i < h.size()) begin
         lo = h[i];
         i++;
         hasUp = 1'b0;
         up = '0;
         // A new packet may take lane 32 only with straddle and no discard
         if (i < h.size() && (!lo.eop || (straddleOn && !lo.disc))) begin
            up = h[i];
            i++;
            hasUp = 1'b1;
         end
         f = '0;
         f.disc = (lo.eop && lo.disc) || (up.eop && up.disc);
         if (lo.sop) begin
            f.packetStartFlags = FLAGS_ONE;
            f.firstStartLanePointer = LANE0_PTR;
            if (up.sop) begin
               f.packetStartFlags = FLAGS_TWO;
               f.secondStartLanePointer = LANE32_PTR;
            end
         end else if (up.sop) begin
            f.packetStartFlags = FLAGS_ONE;
            f.firstStartLanePointer = LANE32_PTR;
         end
         if (lo.eop) begin
            f.packetEndFlags = FLAGS_ONE;
            f.firstEndDwordOffset = {1'h0, lo.lastDw};
            if (up.eop) begin
               f.packetEndFlags = FLAGS_TWO;
               f.secondEndDwordOffset = {1'h1, up.lastDw};
            end
         end else if (up.eop) begin
            f.packetEndFlags = FLAGS_ONE;
            f.firstEndDwordOffset = {1'h1, up.lastDw};
         end
         b.data = {up.data, lo.data};
         b.side = {f, 80'h0};
         b.last = hasUp ? up.eop : lo.eop;
         expQ.push_back(b);
      end
   endtask

   // ==========================================================
   // Segment driver
   task automatic send_pkts(input int n, input bit withDisc);
      seg_t h;
      seg_t hq[$];
      int   len;
      bit   dsc;
      for (int p = 0; p < n; p++) begin
         len = 1 + $urandom_range(3);
         dsc = withDisc && len > 1 && $urandom_range(2) == 0;
         for (int k = 0; k < len; k++) begin
            for (int j = 0; j < 8; j++) begin
               h.data[j*32 +: 32] = $urandom;
            end
            h.sop    = (k == 0);
            h.eop    = (k == len - 1);
            h.disc   = h.eop && dsc;
            h.lastDw = h.eop ? 3'($urandom_range(7)) : 3'h7;
            hq.push_back(h);
         end
      end
      expPkts += n;
      allPkts += n;
      model(hq);
      foreach (hq[k]) begin
         segIn    <= hq[k];
         segValid <= 1'h1;
         do @(posedge clock); while (segReady !== 1'h1);
      end
      segValid <= 1'h0;
   endtask

   task automatic wait_idle();
      for (int k = 0; k < 3000 && expQ.size() != 0; k++) begin
         @(posedge clock);
      end
      check_word(32'h0, 32'(expQ.size()));
      repeat (4) @(posedge clock);
   endtask

   // ==========================================================
   // Beat monitor
   always @(posedge clock) begin
      if (rstn && requestStreamValid === 1'h1 && requestStreamReady === 1'h1) begin
         expBeat = (expQ.size() != 0) ? expQ.pop_front() : '0;
         check_beat(expBeat, {requestStreamData, requestStreamSideband, requestStreamLast});
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(82));
      repeat (3) @(posedge clock);
      rstn <= 1'h1;
      @(posedge clock);
      // Reset values, unmapped place ignored
      reg_read(CTRL_OFS, rd);
      check_word(32'h0, rd);
      reg_read(STATUS_OFS, rd);
      check_word(32'h0, rd);
      reg_write(4'h8, 32'hffffffff);
      reg_read(4'h8, rd);
      check_word(32'h0, rd);
      reg_read(CTRL_OFS, rd);
      check_word(32'h0, rd);
      // One packet per beat
      stallPct <= 7'h1e;
      send_pkts(12, 1'b0);
      wait_idle();
      check_word(32'(expPkts), {16'h0, lastCount});
      reg_read(STATUS_OFS, rd);
      check_word(32'(expPkts), rd);
      reg_write(STATUS_OFS, 32'h0);
      expPkts = 0;
      reg_read(STATUS_OFS, rd);
      check_word(32'h0, rd);
      // Straddled packets with discards
      reg_write(CTRL_OFS, 32'h1);
      straddleOn = 1'b1;
      reg_read(CTRL_OFS, rd);
      check_word(32'h1, rd);
      send_pkts(16, 1'b1);
      wait_idle();
      // Fill the buffer against a stalled receiver, then drain
      stallPct <= 7'h64;
      fork
         send_pkts(16, 1'b0);
         begin
            repeat (30) @(posedge clock);
            check_word(32'h0, {31'h0, segReady});
            stallPct <= 7'h00;
         end
      join
      wait_idle();
      reg_read(STATUS_OFS, rd);
      check_word(32'(expPkts), rd);
      check_word(32'(allPkts), {16'h0, startCount});
      print_verdict();
   end

   // Cut a hang well past the expected run length
   initial begin
      repeat (20000) @(posedge clock);
      numErrors++;
      print_verdict();
   end
endmodule
